// ---- core/ffh_frame_sync.v ----
// Purpose: front-end handler of broadcast frame/slice timing commands
// Assumes: global clock and command lines arrive as pins, sampled here
// Notes:   hit records {frame, slice, time} leave through a 4-word fifo
//
// Functional notes
// - load-index near each frame end except last; last frame-begin closes.
// - frame-begin opens first slice and closes last slice with frame.
// - inside an active frame, segment-begin closes and opens a slice.
// - time runs uniformly from frame start; each hit is stamped.
// - internal tick counter wraps from maximum back to zero.
// - zero method clears time base at frame start; tick locked to clock.
// - capture method stores tick at slice start; hit time is difference.
// - pending index has valid flag: cleared initially and by frame-begin.
// - load-index stores the frame number and marks pending valid.
// - frame-active status kept; hits tagged with frame and slice.
// - reset has top priority, stops hits and sending, drops buffers.
// - reset clears active and pending valid; config ready after delay (code restarts the delay on rst_n_in only).
// - all synchronous commands ignored while reset is asserted.
// - after release commands act; frame-begin depends on active and valid.
// - frame-begin with valid pending: time step, load index, slice zero.
// - inactive with valid pending starts frame; without it, ignored.
// - active with invalid pending closes frame, keeps draining data.
`include "ffh_defs.vh"

module ffh_frame_sync (
    input  wire                    sys_clk_in,
    input  wire                    rst_n_in,
    input  wire                    gclk_in,
    input  wire                    fe_reset_in,
    input  wire [`FFH_CMD_W-1:0]   cmd_code_in,
    input  wire [`FFH_FRAME_W-1:0] cmd_frame_in,
    input  wire                    method_capture_in,
    input  wire                    hit_in,
    input  wire                    out_ready_in,
    output reg                     out_valid_out,
    output reg  [`FFH_REC_W-1:0]   out_data_out,
    output reg                     frame_active_out,
    output reg                     pending_valid_out,
    output reg  [`FFH_FRAME_W-1:0] frame_index_out,
    output reg  [`FFH_SLICE_W-1:0] slice_count_out,
    output reg                     digitizing_out,
    output reg                     cfg_ready_out,
    output reg                     hit_overflow_out
);

    // --------
    // pin synchronisers
    // --------
    // two stages each; stage two feeds logic, and clock and hit add a third delay flop for the edge detect
    reg                    gclk_s1_r;
    reg                    gclk_s2_r;
    reg                    gclk_d_r;
    reg                    rst_s1_r;
    reg                    rst_s2_r;
    reg                    hit_s1_r;
    reg                    hit_s2_r;
    reg                    hit_d_r;
    reg [`FFH_CMD_W-1:0]   cmd_s1_r;
    reg [`FFH_CMD_W-1:0]   cmd_s2_r;
    reg [`FFH_FRAME_W-1:0] frm_s1_r;
    reg [`FFH_FRAME_W-1:0] frm_s2_r;

    // command lines travel with the clock pin, so same latency keeps
    // them aligned to the detected edge
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            gclk_s1_r <= 1'b1; // high: no false edge after reset
            gclk_s2_r <= 1'b1;
            gclk_d_r  <= 1'b1;
            rst_s1_r  <= 1'b1;
            rst_s2_r  <= 1'b1;
            hit_s1_r  <= 1'b0;
            hit_s2_r  <= 1'b0;
            hit_d_r   <= 1'b0;
            cmd_s1_r  <= `FFH_CMD_NONE;
            cmd_s2_r  <= `FFH_CMD_NONE;
            frm_s1_r  <= `FFH_FRAME_ZERO;
            frm_s2_r  <= `FFH_FRAME_ZERO;
        end else begin
            gclk_s1_r <= gclk_in;
            gclk_s2_r <= gclk_s1_r;
            gclk_d_r  <= gclk_s2_r;
            rst_s1_r  <= fe_reset_in;
            rst_s2_r  <= rst_s1_r;
            hit_s1_r  <= hit_in;
            hit_s2_r  <= hit_s1_r;
            hit_d_r   <= hit_s2_r;
            cmd_s1_r  <= cmd_code_in;
            cmd_s2_r  <= cmd_s1_r;
            frm_s1_r  <= cmd_frame_in;
            frm_s2_r  <= frm_s1_r;
        end
    end

    // --------
    // command decode
    // --------
    wire gclk_rise;
    wire in_reset;
    wire hit_rise;
    wire cmd_load;
    wire cmd_frame;
    wire cmd_seg;

    assign gclk_rise = gclk_s2_r & ~gclk_d_r;
    assign in_reset  = rst_s2_r;
    assign hit_rise  = hit_s2_r & ~hit_d_r;
    // reset masks every command while it is held
    assign cmd_load  = gclk_rise & ~in_reset &
                       (cmd_s2_r == `FFH_CMD_LOAD_IDX);
    assign cmd_frame = gclk_rise & ~in_reset &
                       (cmd_s2_r == `FFH_CMD_FRAME_BEG);
    assign cmd_seg   = gclk_rise & ~in_reset &
                       (cmd_s2_r == `FFH_CMD_SEG_BEG);

    // --------
    // frame state
    // --------
    reg                    active_r;
    reg                    pend_valid_r;
    reg [`FFH_FRAME_W-1:0] pend_idx_r;
    reg [`FFH_FRAME_W-1:0] frame_idx_r;
    reg [`FFH_SLICE_W-1:0] slice_r;
    reg                    digit_r;

    wire frame_open;
    wire frame_close;

    // a valid pending index always opens a new frame, whether or not
    // one was already running (back-to-back frames in a batch)
    assign frame_open  = cmd_frame & pend_valid_r;
    assign frame_close = cmd_frame & active_r & ~pend_valid_r;

    // the state machine of the frame handler
    always @(posedge sys_clk_in) begin
        if (!rst_n_in || in_reset) begin
            active_r     <= 1'b0;
            pend_valid_r <= 1'b0;
            digit_r      <= 1'b0;
            pend_idx_r   <= `FFH_FRAME_ZERO;
            frame_idx_r  <= `FFH_FRAME_ZERO;
            slice_r      <= `FFH_SLICE_ZERO;
        end else begin
            if (cmd_load) begin
                pend_idx_r   <= frm_s2_r;
                pend_valid_r <= 1'b1;
            end else if (cmd_frame) begin
                pend_valid_r <= 1'b0;
            end
            if (frame_open) begin
                frame_idx_r <= pend_idx_r;
                slice_r     <= `FFH_SLICE_ZERO;
                active_r    <= 1'b1;
                digit_r     <= 1'b1;
            end else if (frame_close) begin
                active_r    <= 1'b0;
                digit_r     <= 1'b0;
            end else if (cmd_seg && active_r) begin
                slice_r     <= slice_r + `FFH_SLICE_ONE;
            end
            // frame-begin while inactive with no pending: no action
        end
    end

    // --------
    // time base
    // --------
    // tick runs at the system clock, 8x the global clock and locked to
    // it through the sampled edge, so frame zero lands on a global edge
    reg [`FFH_TICK_W-1:0] tick_r;
    reg [`FFH_TICK_W-1:0] slice_t0_r;

    wire slice_start;
    assign slice_start = frame_open | (cmd_seg & active_r);

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            tick_r     <= `FFH_TICK_ZERO;
            slice_t0_r <= `FFH_TICK_ZERO;
        end else begin
            if (frame_open && !method_capture_in) begin
                tick_r <= `FFH_TICK_ZERO;
            end else begin
                tick_r <= tick_r + `FFH_TICK_ONE;
            end
            if (slice_start && method_capture_in) begin
                slice_t0_r <= tick_r;
            end
        end
    end

    // hit time: raw tick, or modular difference from the slice start
    wire [`FFH_TICK_W-1:0] hit_time;
    assign hit_time = method_capture_in ? (tick_r - slice_t0_r)
                                        : tick_r;

    // --------
    // hit capture into the fifo
    // --------
    // one holding slot in front of the fifo; a hit arriving while the
    // slot is still blocked is dropped and flagged, since a pin hit
    // cannot be stalled
    reg                  hold_valid_r;
    reg [`FFH_REC_W-1:0] hold_data_r;
    reg                  ovf_r;

    wire                  fifo_in_ready;
    wire                  fifo_out_valid;
    wire [`FFH_REC_W-1:0] fifo_out_data;
    wire                  fifo_pop;
    wire                  hold_take;

    assign hold_take = hold_valid_r & fifo_in_ready;

    always @(posedge sys_clk_in) begin
        if (!rst_n_in || in_reset) begin
            hold_valid_r <= 1'b0;
            hold_data_r  <= {`FFH_REC_W{1'b0}};
            ovf_r        <= 1'b0;
        end else begin
            if (hit_rise && digit_r &&
                    (!hold_valid_r || hold_take)) begin
                hold_valid_r <= 1'b1;
                hold_data_r  <= {frame_idx_r, slice_r, hit_time};
            end else if (hold_take) begin
                hold_valid_r <= 1'b0;
            end
            if (hit_rise && digit_r && hold_valid_r && !hold_take) begin
                ovf_r <= 1'b1;
            end
        end
    end

    ffh_fifo #(
        .WIDTH (`FFH_REC_W),
        .DEPTH (`FFH_FIFO_DEPTH),
        .AW    (`FFH_FIFO_AW)
    ) u_fifo (
        .clk_in        (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .flush_in      (in_reset),
        .in_valid_in   (hold_valid_r),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (hold_data_r),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_out_data)
    );

    // --------
    // output stage
    // --------
    // registered stage keeps outputs on flops; it keeps draining after
    // a frame closes and only reset stops it
    assign fifo_pop = fifo_out_valid & ~in_reset &
                      (~out_valid_out | out_ready_in);

    always @(posedge sys_clk_in) begin
        if (!rst_n_in || in_reset) begin
            out_valid_out <= 1'b0;
            out_data_out  <= {`FFH_REC_W{1'b0}};
        end else if (fifo_pop) begin
            out_valid_out <= 1'b1;
            out_data_out  <= fifo_out_data;
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end

    // --------
    // configuration readiness after reset
    // --------
    // the config port is held off for a settle time after each rst_n_in reset; fe_reset_in does not restart it
    reg [`FFH_CFG_CNT_W-1:0] cfg_cnt_r;

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cfg_cnt_r     <= {`FFH_CFG_CNT_W{1'b0}};
            cfg_ready_out <= 1'b0;
        end else if (cfg_cnt_r ==
                     `FFH_CFG_DELAY_CYC) begin
            cfg_ready_out <= 1'b1;
        end else begin
            cfg_cnt_r     <= cfg_cnt_r + {{(`FFH_CFG_CNT_W-1){1'b0}}, 1'b1};
            cfg_ready_out <= 1'b0;
        end
    end

    // --------
    // status outputs, one flop each
    // --------
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            frame_active_out  <= 1'b0;
            pending_valid_out <= 1'b0;
            frame_index_out   <= `FFH_FRAME_ZERO;
            slice_count_out   <= `FFH_SLICE_ZERO;
            digitizing_out    <= 1'b0;
            hit_overflow_out  <= 1'b0;
        end else begin
            frame_active_out  <= active_r;
            pending_valid_out <= pend_valid_r;
            frame_index_out   <= frame_idx_r;
            slice_count_out   <= slice_r;
            digitizing_out    <= digit_r;
            hit_overflow_out  <= ovf_r;
        end
    end

endmodule // ffh_frame_sync

// ---- core/ffh_defs.vh ----
// Purpose: shared constants of the frame sync command handler
// Assumes: 125 MHz system clock, parallel command lines on the link
// Notes:   definitions only
`ifndef FFH_DEFS_VH
`define FFH_DEFS_VH

// --------
// command codes on the synchronous command lines
// --------
`define FFH_CMD_W          2
`define FFH_CMD_NONE       2'h0
`define FFH_CMD_LOAD_IDX   2'h1
`define FFH_CMD_FRAME_BEG  2'h2
`define FFH_CMD_SEG_BEG    2'h3

// --------
// field widths of the hit record {frame, slice, time}
// --------
`define FFH_FRAME_W        16
`define FFH_SLICE_W        12
`define FFH_TICK_W         16
`define FFH_REC_W          44
`define FFH_FRAME_ZERO     16'h0000
`define FFH_SLICE_ZERO     12'h000
`define FFH_TICK_ZERO      16'h0000
`define FFH_SLICE_ONE      12'h001
`define FFH_TICK_ONE       16'h0001

// --------
// buffering
// --------
`define FFH_FIFO_DEPTH     4
`define FFH_FIFO_AW        2

// --------
// timing: settle delay before the config port is ready
// --------
`define FFH_CLK_PERIOD_NS  8
`define FFH_CFG_DELAY_NS   1000
`define FFH_CFG_DELAY_CYC  ((`FFH_CFG_DELAY_NS + `FFH_CLK_PERIOD_NS - 1) / `FFH_CLK_PERIOD_NS)
`define FFH_CFG_CNT_W      8

`endif

// ---- core/ffh_fifo.v ----
// Purpose: small synchronous fifo for hit records
// Assumes: single clock, synchronous active-low reset
// Notes:   flush_in empties the fifo in one cycle
module ffh_fifo #(
    parameter WIDTH = 44,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_in,
    input  wire             rst_n_in,
    input  wire             flush_in,
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;

    wire push;
    wire pop;

    // --------
    // handshakes and honest full/empty
    // --------
    assign in_ready_out  = (count_r != DEPTH[AW:0]);
    assign out_valid_out = (count_r != {(AW+1){1'b0}});
    assign out_data_out  = mem_r[rd_ptr_r];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // storage; no reset needed, contents qualified by count
    always @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always @(posedge clk_in) begin
        if (!rst_n_in || flush_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            end
            case ({push, pop})
                2'b10:   count_r <= count_r + {{AW{1'b0}}, 1'b1};
                2'b01:   count_r <= count_r - {{AW{1'b0}}, 1'b1};
                default: count_r <= count_r;
            endcase
        end
    end

endmodule // ffh_fifo

// ---- sim/ffh_frame_sync_props.sv ----
// Purpose: port-level checks on the frame sync command handler
// Assumes: one sys clock domain, synchronous active-low reset
// Notes:   bound to every ffh_frame_sync instance
`include "ffh_defs.vh"
module ffh_frame_sync_props (
    input wire                    sys_clk_in,
    input wire                    rst_n_in,
    input wire                    fe_reset_in,
    input wire                    out_ready_in,
    input wire                    out_valid_out,
    input wire [`FFH_REC_W-1:0]   out_data_out,
    input wire                    frame_active_out,
    input wire                    pending_valid_out,
    input wire [`FFH_FRAME_W-1:0] frame_index_out,
    input wire [`FFH_SLICE_W-1:0] slice_count_out,
    input wire                    digitizing_out,
    input wire                    cfg_ready_out
);
    // --------
    // helper counters: reset pin high/low runs, cycles since release
    // --------
    reg [3:0] fr_hi_r;
    reg [3:0] fr_lo_r;
    reg [7:0] rel_r;
    // saturating, so long runs never wrap back into a false antecedent
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            fr_hi_r <= 4'h0;
            fr_lo_r <= 4'h0;
            rel_r   <= 8'h00;
        end else begin
            fr_hi_r <= !fe_reset_in ? 4'h0 : fr_hi_r + {3'h0, fr_hi_r != 4'hf};
            fr_lo_r <= fe_reset_in ? 4'h0 : fr_lo_r + {3'h0, fr_lo_r != 4'hf};
            rel_r   <= rel_r + {7'h00, rel_r != 8'hff};
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // --------
    // assertions
    // --------
    reset_clears_a: assert property (
        $past(!rst_n_in) |-> !frame_active_out && !pending_valid_out
            && !out_valid_out && !digitizing_out)
        else $error("status not cleared after reset");
    fe_reset_clears_a: assert property (
        fr_hi_r >= 4'h8 |-> !frame_active_out && !pending_valid_out
            && !out_valid_out && slice_count_out == `FFH_SLICE_ZERO)
        else $error("state kept while aggregator reset held");
    out_hold_a: assert property (
        out_valid_out && !out_ready_in && fr_lo_r >= 4'h6
            |=> out_valid_out && $stable(out_data_out))
        else $error("record dropped or changed before accepted");
    frame_open_a: assert property (
        $rose(frame_active_out) |-> $fell(pending_valid_out)
            && slice_count_out == `FFH_SLICE_ZERO)
        else $error("frame opened without using pending index");
    slice_step_a: assert property (
        $changed(slice_count_out) |-> slice_count_out == `FFH_SLICE_ZERO
            || slice_count_out == $past(slice_count_out) + `FFH_SLICE_ONE)
        else $error("slice count moved by other than one");
    slice_active_a: assert property (
        $changed(slice_count_out) && slice_count_out != `FFH_SLICE_ZERO
            |-> frame_active_out)
        else $error("slice advanced outside a frame");
    index_load_a: assert property (
        $changed(frame_index_out) && frame_index_out != `FFH_FRAME_ZERO
            |-> $fell(pending_valid_out))
        else $error("frame index changed without pending index");
    digit_follow_a: assert property (
        digitizing_out == frame_active_out)
        else $error("digitizing differs from frame status");
    cfg_delay_a: assert property (
        $rose(cfg_ready_out) |-> rel_r >= 8'h7b && rel_r <= 8'h81)
        else $error("config ready at wrong delay");
endmodule // ffh_frame_sync_props

bind ffh_frame_sync ffh_frame_sync_props u_props (
    .sys_clk_in        (sys_clk_in),
    .rst_n_in          (rst_n_in),
    .fe_reset_in       (fe_reset_in),
    .out_ready_in      (out_ready_in),
    .out_valid_out     (out_valid_out),
    .out_data_out      (out_data_out),
    .frame_active_out  (frame_active_out),
    .pending_valid_out (pending_valid_out),
    .frame_index_out   (frame_index_out),
    .slice_count_out   (slice_count_out),
    .digitizing_out    (digitizing_out),
    .cfg_ready_out     (cfg_ready_out)
);

// ---- sim/ffh_aggr_model.sv ----
// Purpose: first-level aggregator model: global clock, commands, reset
// Assumes: command lines change on the falling global clock edge
// Notes:   global clock runs free; reset line starts asserted
`include "ffh_defs.vh"
module ffh_aggr_model (
    output reg                    gclk_out,
    output reg                    fe_reset_out,
    output reg [`FFH_CMD_W-1:0]   cmd_code_out,
    output reg [`FFH_FRAME_W-1:0] cmd_frame_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // global clock, offset so its edges never meet sys clock edges
    // --------
    initial begin
        gclk_out      = 1'b0;
        fe_reset_out  = 1'b1; // disarmed, no commands yet
        cmd_code_out  = `FFH_CMD_NONE;
        cmd_frame_out = `FFH_FRAME_ZERO;
        #3;
        forever #32 gclk_out = ~gclk_out;
    end
    // one command per global period, held across its rising edge
    task send_cmd(input [`FFH_CMD_W-1:0] c, input [`FFH_FRAME_W-1:0] f);
        begin
            @(negedge gclk_out);
            cmd_code_out  = c;
            cmd_frame_out = f;
            @(negedge gclk_out);
            cmd_code_out  = `FFH_CMD_NONE;
            cmd_frame_out = ~f; // released lines must not keep the value
        end
    endtask
    // arm and disarm only move the reset line
    task set_reset(input v);
        begin
            @(negedge gclk_out);
            fe_reset_out = v;
        end
    endtask
endmodule // ffh_aggr_model

// ---- sim/ffh_frame_sync_bench.sv ----
// Purpose: self-checking bench for the frame sync command handler
// Assumes: 125 MHz sys clock, aggregator model drives the link pins
// Notes:   hit pulses are 4 cycles high, 4 low, so 8 ticks apart
`include "ffh_defs.vh"
module ffh_frame_sync_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg                     sys_clk_in = 1'b0;
    reg                     rst_n_in = 1'b0;
    reg                     hit_in = 1'b0;
    reg                     out_ready_in = 1'b0;
    reg                     method_capture_in = 1'b0;
    wire                    gclk, fe_reset, out_valid_out, cfg_ready_out;
    wire                    frame_active_out, pending_valid_out;
    wire                    digitizing_out, hit_overflow_out;
    wire [`FFH_CMD_W-1:0]   cmd_code;
    wire [`FFH_FRAME_W-1:0] cmd_frame, frame_index_out;
    wire [`FFH_SLICE_W-1:0] slice_count_out;
    wire [`FFH_REC_W-1:0]   out_data_out;
    reg  [`FFH_REC_W-1:0]   rec, prev;
    reg  [15:0]             dt;
    integer                 n_mismatch = 0;
    integer                 tests_run = 0;

    always #4 sys_clk_in = ~sys_clk_in;

    ffh_aggr_model m_aggr (.gclk_out(gclk), .fe_reset_out(fe_reset),
        .cmd_code_out(cmd_code), .cmd_frame_out(cmd_frame));
    ffh_frame_sync DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .gclk_in(gclk), .fe_reset_in(fe_reset), .cmd_code_in(cmd_code),
        .cmd_frame_in(cmd_frame), .method_capture_in(method_capture_in),
        .hit_in(hit_in), .out_ready_in(out_ready_in),
        .out_valid_out(out_valid_out), .out_data_out(out_data_out),
        .frame_active_out(frame_active_out),
        .pending_valid_out(pending_valid_out),
        .frame_index_out(frame_index_out),
        .slice_count_out(slice_count_out),
        .digitizing_out(digitizing_out), .cfg_ready_out(cfg_ready_out),
        .hit_overflow_out(hit_overflow_out));

    // --------
    // shared tasks
    // --------
    task check(input [8*12-1:0] what, input [47:0] seen, input [47:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // outputs settle within 4 cycles after the global edge; sample late
    task cmd(input [1:0] c, input [15:0] f);
        begin
            m_aggr.send_cmd(c, f);
            tick(8);
            @(negedge sys_clk_in);
        end
    endtask
    task stat(input a, input p, input [15:0] f, input [11:0] s);
        begin
            check("active", frame_active_out, a);
            check("digitizing", digitizing_out, a);
            check("pending", pending_valid_out, p);
            check("frame", frame_index_out, f);
            check("slice", slice_count_out, s);
        end
    endtask
    task hit_pulse;
        begin
            @(posedge sys_clk_in);
            hit_in <= 1'b1;
            tick(4);
            hit_in <= 1'b0;
            tick(3);
        end
    endtask
    // ready is raised only after valid is seen, then held for one edge
    task pop(output [`FFH_REC_W-1:0] r);
        integer i;
        begin
            i = 0;
            @(negedge sys_clk_in);
            while (out_valid_out !== 1'b1 && i < 50) begin
                @(negedge sys_clk_in);
                i = i + 1;
            end
            r = out_data_out;
            @(posedge sys_clk_in);
            out_ready_in <= 1'b1;
            @(posedge sys_clk_in);
            out_ready_in <= 1'b0;
            check("pop_wait", i < 50, 1'b1);
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // --------
    // scenarios
    // --------
    task t_reset;
        begin
            tick(6);
            rst_n_in <= 1'b1;
            tick(120);
            @(negedge sys_clk_in);
            check("cfg_early", cfg_ready_out, 1'b0);
            tick(10);
            @(negedge sys_clk_in);
            check("cfg_ready", cfg_ready_out, 1'b1);
            stat(1'b0, 1'b0, 16'h0000, 12'h000);
            $display("test reset done");
        end
    endtask
    // stray commands before a pending index must do nothing
    task t_open;
        begin
            m_aggr.set_reset(1'b0);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0009);
            stat(1'b0, 1'b0, 16'h0000, 12'h000);
            cmd(`FFH_CMD_SEG_BEG, 16'h0000);
            stat(1'b0, 1'b0, 16'h0000, 12'h000);
            cmd(`FFH_CMD_LOAD_IDX, 16'h0005);
            stat(1'b0, 1'b1, 16'h0000, 12'h000);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0000);
            stat(1'b1, 1'b0, 16'h0005, 12'h000);
            cmd(`FFH_CMD_SEG_BEG, 16'h0000);
            cmd(`FFH_CMD_SEG_BEG, 16'h0000);
            stat(1'b1, 1'b0, 16'h0005, 12'h002);
            $display("test open done");
        end
    endtask
    // sink stalls: 6 records fit, the 7th hit is dropped
    task t_stream;
        begin
            repeat (7) hit_pulse;
            tick(6);
            @(negedge sys_clk_in);
            check("overflow", hit_overflow_out, 1'b1);
            pop(prev);
            check("tag", prev[43:16], {16'h0005, 12'h002});
            repeat (5) begin
                pop(rec);
                dt = rec[15:0] - prev[15:0];
                check("tag", rec[43:16], {16'h0005, 12'h002});
                check("tick_step", dt, 16'h0008);
                prev = rec;
            end
            tick(4);
            @(negedge sys_clk_in);
            check("drained", out_valid_out, 1'b0);
            $display("test stream done");
        end
    endtask
    task t_close;
        begin
            cmd(`FFH_CMD_LOAD_IDX, 16'h0006);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0000);
            stat(1'b1, 1'b0, 16'h0006, 12'h000);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0000);
            check("closed", frame_active_out, 1'b0);
            check("no_digit", digitizing_out, 1'b0);
            hit_pulse;
            tick(10);
            @(negedge sys_clk_in);
            check("no_record", out_valid_out, 1'b0);
            $display("test close done");
        end
    endtask
    // a buffered record must vanish and commands be ignored in reset
    task t_fereset;
        begin
            cmd(`FFH_CMD_LOAD_IDX, 16'h0007);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0000);
            hit_pulse;
            tick(6);
            @(negedge sys_clk_in);
            check("rec_wait", out_valid_out, 1'b1);
            m_aggr.set_reset(1'b1);
            cmd(`FFH_CMD_LOAD_IDX, 16'h0008);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0000);
            stat(1'b0, 1'b0, 16'h0000, 12'h000);
            check("discarded", out_valid_out, 1'b0);
            m_aggr.set_reset(1'b0);
            cmd(`FFH_CMD_LOAD_IDX, 16'h0008);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0000);
            stat(1'b1, 1'b0, 16'h0008, 12'h000);
            $display("test link reset done");
        end
    endtask
    task t_rst_mid;
        begin
            @(posedge sys_clk_in);
            rst_n_in <= 1'b0;
            tick(3);
            rst_n_in <= 1'b1;
            tick(2);
            @(negedge sys_clk_in);
            check("ovf_clear", hit_overflow_out, 1'b0);
            check("inactive", frame_active_out, 1'b0);
            $display("test mid reset done");
        end
    endtask
    // capture method: hit time counts from the slice start
    task t_capture;
        begin
            @(posedge sys_clk_in);
            method_capture_in <= 1'b1;
            cmd(`FFH_CMD_LOAD_IDX, 16'h0009);
            cmd(`FFH_CMD_FRAME_BEG, 16'h0000);
            cmd(`FFH_CMD_SEG_BEG, 16'h0000);
            hit_pulse;
            pop(rec);
            check("cap_tag", rec[43:16], {16'h0009, 12'h001});
            check("cap_time", rec[15:0] < 16'h0018, 1'b1);
            $display("test capture done");
        end
    endtask

    initial begin
        t_reset;
        t_open;
        t_stream;
        t_close;
        t_fereset;
        t_rst_mid;
        t_capture;
        end_of_test;
    end
    // the whole run needs well under 10,000 cycles
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        end_of_test;
    end
endmodule // ffh_frame_sync_bench
